// ### pkg/ecpw_pkg.sv
// Package with the register map, field positions and mode codes of the capture/compare/PWM unit.
package ecpw_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DUTY = 8'h04;
   localparam logic [7:0] OFS_CMP = 8'h08;
   localparam logic [7:0] OFS_PER = 8'h0C;
   localparam logic [7:0] OFS_PCTL = 8'h10;
   localparam logic [7:0] OFS_TMR = 8'h14;
   localparam logic [7:0] OFS_FLAG = 8'h18;
   localparam logic [7:0] OFS_IEN = 8'h1C;
   localparam logic [7:0] OFS_SDC = 8'h20;
   localparam logic [7:0] OFS_PCFG = 8'h24;
   localparam logic [7:0] OFS_MISC = 8'h28;
   localparam logic [7:0] OFS_CMP2 = 8'h2C;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int STEER_LSB = 6;
   localparam int DUTYLO_LSB = 4;
   localparam int FLG_OVF = 0;
   localparam int FLG_CH = 1;
   localparam int PCTL_ON = 2;
   localparam int SDC_ACT = 7;
   localparam int SDC_SRC = 4;
   localparam int SDC_AC_LSB = 2;
   localparam int SDC_BD_LSB = 0;
   localparam int PCFG_RESTART = 7;
   localparam int MISC_TSEL = 0;
   localparam int MISC_ADCEN = 1;
   localparam int CMP2_MODE_LSB = 16;
   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PER_RST = 8'hFF;
   localparam logic [15:0] TMR_RST = 16'h0000;
   localparam logic [15:0] TMR_MAX = 16'hFFFF;
   localparam int INSTR_CLKS = 4;
   // ----------------------------------------------------------------
   // Mode, steering and prescale codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CMP_TOG = 4'h2;
   localparam logic [3:0] MODE_CAP_ANY = 4'h3;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_R4 = 4'h6;
   localparam logic [3:0] MODE_CAP_R16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SW = 4'hA;
   localparam logic [3:0] MODE_CMP_SPEC = 4'hB;
   localparam logic [1:0] STEER_SINGLE = 2'h0;
   localparam logic [1:0] STEER_FWD = 2'h1;
   localparam logic [1:0] STEER_HALF = 2'h2;
   localparam logic [1:0] STEER_REV = 2'h3;
   localparam logic [1:0] PRE_1 = 2'h0;
   localparam logic [1:0] PRE_4 = 2'h1;
endpackage : ecpw_pkg

// ### src/ecpw_dead_band.sv
// Turn-on delay of one bridge output, counted in instruction cycles.
`timescale 1ns/100ps
module ecpw_dead_band
   import ecpw_pkg::*;
#(
   parameter int CNT_W = 7
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Drive request and delay
   input wire logic req,
   input wire logic [CNT_W-1:0] delay,
   // Delayed drive
   output logic out_q
);
   logic [CNT_W-1:0] left_q;
   logic [1:0] sub_q;
   logic req_q;
   wire logic rise = req & ~req_q;
   wire logic instr = (sub_q == 2'(INSTR_CLKS - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 1'b0;
         sub_q <= 2'h0;
         left_q <= '0;
         out_q <= 1'b0;
      end else begin
         req_q <= req;
         sub_q <= rise ? 2'h0 : sub_q + 2'h1;
         if (!req) begin
            out_q <= 1'b0;
         end else if (rise) begin
            left_q <= delay;
            out_q <= (delay == '0);
         end else if (left_q != '0) begin
            if (instr) begin
               left_q <= left_q - 1'b1;
               out_q <= (left_q == 1'b1);
            end
         end else begin
            out_q <= 1'b1;
         end
      end
   end
endmodule : ecpw_dead_band

// ### src/ecpw_unit.sv
// Capture/compare/PWM unit with event timer, period timer, steering and APB registers.
`timescale 1ns/100ps
module ecpw_unit
   import ecpw_pkg::*;
#(
   parameter int DB_W = 7
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Time bases
   input wire logic event_tick,
   input wire logic [15:0] alt_timer_value,
   output logic alt_timer_clear,
   // Converter trigger and interrupt
   input wire logic adc_enabled,
   output logic adc_start,
   output logic irq,
   // Fault pin
   input wire logic fault_n_i,
   // Bridge pins
   input wire logic bridge_out_a_i,
   output logic bridge_out_a_o,
   output logic bridge_out_a_oe_n,
   output logic bridge_out_b_o,
   output logic bridge_out_b_oe_n,
   output logic bridge_out_c_o,
   output logic bridge_out_c_oe_n,
   output logic bridge_out_d_o,
   output logic bridge_out_d_oe_n
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q, duty_q, per_q, pcfg_q;
   logic [2:0] pctl_q;
   logic [15:0] cmp_q, cmp2_q, event_timer_q;
   logic [3:0] mode2_q;
   logic [1:0] flag_q, ien_q, misc_q;
   logic sd_flag_q, sd_src_q, sd_hold_q;
   logic [3:0] sd_state_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, irq_q, adc_start_q, alt_clr_q;
   logic [1:0] qcyc_q;
   logic [3:0] pre_q, cap_cnt_q, pin_q, oe_n_q;
   logic [7:0] pwm_tmr_q;
   logic [9:0] dbuf_q;
   logic pwm_raw_q, cmp_pin_q, eq_q, eq2_q;
   logic cap_s1_q, cap_s2_q, cap_s3_q, flt_s1_q, flt_s2_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic setup = psel & ~penable;
   wire logic wr = psel & penable & pready_q & pwrite;
   wire logic wr_ctrl = wr & (paddr == OFS_CTRL);
   wire logic wr_tmr = wr & (paddr == OFS_TMR);
   wire logic wr_flag = wr & (paddr == OFS_FLAG);
   wire logic wr_sdc = wr & (paddr == OFS_SDC);
   wire logic [3:0] mode = ctrl_q[3:0];
   wire logic [1:0] steer = ctrl_q[STEER_LSB+1:STEER_LSB];
   wire logic [9:0] duty_prog = {duty_q, ctrl_q[DUTYLO_LSB+1:DUTYLO_LSB]};
   wire logic pwm_mode = (mode[3:2] == 2'b11);
   wire logic cap_mode = (mode >= MODE_CAP_ANY) && (mode <= MODE_CAP_R16);
   wire logic cmp_mode = (mode == MODE_CMP_TOG) || (mode[3:2] == 2'b10);
   wire logic tsel = misc_q[MISC_TSEL];
   wire logic [15:0] sel_tmr = tsel ? alt_timer_value : event_timer_q;
   logic [31:0] rdata;
   logic hit;

   always_comb begin
      rdata = 32'h0;
      hit = 1'b1;
      case (paddr)
         OFS_CTRL: rdata = {24'h0, ctrl_q};
         OFS_DUTY: rdata = {24'h0, duty_q};
         OFS_CMP: rdata = {16'h0, cmp_q};
         OFS_PER: rdata = {24'h0, per_q};
         OFS_PCTL: rdata = {29'h0, pctl_q};
         OFS_TMR: rdata = {16'h0, event_timer_q};
         OFS_FLAG: rdata = {30'h0, flag_q};
         OFS_IEN: rdata = {30'h0, ien_q};
         OFS_SDC: rdata = {24'h0, sd_flag_q, 2'h0, sd_src_q, sd_state_q};
         OFS_PCFG: rdata = {24'h0, pcfg_q};
         OFS_MISC: rdata = {30'h0, misc_q};
         OFS_CMP2: rdata = {12'h0, mode2_q, cmp2_q};
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Capture and compare
   // ----------------------------------------------------------------
   wire logic rise = cap_s2_q & ~cap_s3_q;
   wire logic fall = ~cap_s2_q & cap_s3_q;
   logic cap_evt;
   always_comb begin
      case (mode)
         MODE_CAP_ANY: cap_evt = rise | fall;
         MODE_CAP_FALL: cap_evt = fall;
         MODE_CAP_RISE: cap_evt = rise;
         MODE_CAP_R4: cap_evt = rise & (cap_cnt_q[1:0] == 2'h3);
         MODE_CAP_R16: cap_evt = rise & (cap_cnt_q == 4'hF);
         default: cap_evt = 1'b0;
      endcase
   end
   wire logic eq = (sel_tmr == cmp_q);
   wire logic cmp_hit = cmp_mode & eq & ~eq_q;
   wire logic enh_spec = cmp_hit & (mode == MODE_CMP_SPEC);
   wire logic eq2 = (event_timer_q == cmp2_q);
   wire logic sec_spec = (mode2_q == MODE_CMP_SPEC) & eq2 & ~eq2_q;
   wire logic tmr_clr = (enh_spec & ~tsel) | sec_spec;
   wire logic wrap = event_tick & ~wr_tmr & ~tmr_clr & (event_timer_q == TMR_MAX);

   // ----------------------------------------------------------------
   // Period timer and duty
   // ----------------------------------------------------------------
   wire logic instr = (qcyc_q == 2'(INSTR_CLKS - 1));
   wire logic [1:0] pre_sel = pctl_q[1:0];
   wire logic ptick = pctl_q[PCTL_ON] & instr & ((pre_sel == PRE_1)
      | ((pre_sel == PRE_4) & (pre_q[1:0] == 2'h3)) | (pre_sel[1] & (pre_q == 4'hF)));
   wire logic [1:0] low2 = (pre_sel == PRE_1) ? qcyc_q
      : ((pre_sel == PRE_4) ? pre_q[1:0] : pre_q[3:2]);
   wire logic pwr = ptick & (pwm_tmr_q == per_q);
   wire logic [9:0] pwm_cnt = {pwm_tmr_q, low2};
   wire logic sd_cause = sd_src_q & ~flt_s2_q;
   wire logic shut = sd_flag_q | sd_hold_q;

   // ----------------------------------------------------------------
   // Steering
   // ----------------------------------------------------------------
   logic db_a, db_b;
   ecpw_dead_band #(.CNT_W(DB_W)) u_db_a (
      .pclk(pclk),
      .presetn(presetn),
      .req(pwm_raw_q),
      .delay((steer == STEER_HALF) ? pcfg_q[DB_W-1:0] : '0),
      .out_q(db_a)
   );
   ecpw_dead_band #(.CNT_W(DB_W)) u_db_b (
      .pclk(pclk),
      .presetn(presetn),
      .req(~pwm_raw_q & pwm_mode),
      .delay(pcfg_q[DB_W-1:0]),
      .out_q(db_b)
   );
   logic [3:0] act, drv;
   always_comb begin
      act = 4'h0;
      drv = 4'h0;
      case (steer)
         STEER_SINGLE: begin
            act = {3'b000, db_a};
            drv = 4'b0001;
         end
         STEER_FWD: begin
            act = {db_a, 3'b001};
            drv = 4'b1111;
         end
         STEER_HALF: begin
            act = {2'b00, db_b, db_a};
            drv = 4'b0011;
         end
         STEER_REV: begin
            act = {2'b01, db_a, 1'b0};
            drv = 4'b1111;
         end
         default: drv = 4'h0;
      endcase
   end
   wire logic [3:0] pol = {mode[0], mode[1], mode[0], mode[1]};
   wire logic [1:0] sac = sd_state_q[SDC_AC_LSB+1:SDC_AC_LSB];
   wire logic [1:0] sbd = sd_state_q[SDC_BD_LSB+1:SDC_BD_LSB];
   wire logic [3:0] sd_lvl = {sbd[0], sac[0], sbd[0], sac[0]};
   wire logic [3:0] sd_drv = {~sbd[1], ~sac[1], ~sbd[1], ~sac[1]};
   wire logic a_cmp_drv = cmp_mode & (mode != MODE_CMP_SW);
   wire logic [3:0] pin_d = pwm_mode ? (shut ? sd_lvl : act ^ pol) : {3'b000, cmp_pin_q};
   wire logic [3:0] drv_d = pwm_mode ? (shut ? (drv & sd_drv) : drv)
      : {3'b000, a_cmp_drv};

   // ----------------------------------------------------------------
   // Sequential logic
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {cap_s1_q, cap_s2_q, cap_s3_q} <= 3'b000;
         {flt_s1_q, flt_s2_q} <= 2'b11;
         {prdata_q, pready_q, pslverr_q} <= '0;
         {irq_q, adc_start_q, alt_clr_q} <= 3'b000;
      end else begin
         cap_s1_q <= bridge_out_a_i;
         cap_s2_q <= cap_s1_q;
         cap_s3_q <= cap_s2_q;
         flt_s1_q <= fault_n_i;
         flt_s2_q <= flt_s1_q;
         pready_q <= setup;
         pslverr_q <= setup & ~hit;
         prdata_q <= setup ? rdata : 32'h0;
         irq_q <= |(flag_q & ien_q);
         adc_start_q <= sec_spec & adc_enabled;
         alt_clr_q <= enh_spec & tsel;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {ctrl_q, duty_q, pcfg_q} <= {CTRL_RST, 16'h0};
         per_q <= PER_RST;
         {pctl_q, misc_q, ien_q, mode2_q} <= '0;
         {cmp_q, cmp2_q} <= '0;
         {sd_src_q, sd_state_q} <= '0;
      end else if (wr) begin
         case (paddr)
            OFS_CTRL: ctrl_q <= pwdata[7:0];
            OFS_DUTY: duty_q <= pwdata[7:0];
            OFS_PER: per_q <= pwdata[7:0];
            OFS_PCTL: pctl_q <= pwdata[2:0];
            OFS_IEN: ien_q <= pwdata[1:0];
            OFS_SDC: {sd_src_q, sd_state_q} <= {pwdata[SDC_SRC], pwdata[3:0]};
            OFS_PCFG: pcfg_q <= pwdata[7:0];
            OFS_MISC: misc_q <= pwdata[1:0];
            OFS_CMP2: {mode2_q, cmp2_q} <= pwdata[CMP2_MODE_LSB+3:0];
            default: ;
         endcase
         if (paddr == OFS_CMP) begin
            cmp_q <= pwdata[15:0];
         end
      end else if (cap_evt) begin
         cmp_q <= sel_tmr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_timer_q <= TMR_RST;
         flag_q <= 2'h0;
         {eq_q, eq2_q, cmp_pin_q} <= 3'b000;
         cap_cnt_q <= 4'h0;
      end else begin
         if (wr_tmr) begin
            event_timer_q <= pwdata[15:0];
         end else if (tmr_clr) begin
            event_timer_q <= TMR_RST;
         end else if (event_tick) begin
            event_timer_q <= event_timer_q + 16'h1;
         end
         flag_q[FLG_OVF] <= wrap | (flag_q[FLG_OVF] & ~(wr_flag & pwdata[FLG_OVF]));
         flag_q[FLG_CH] <= cap_evt | cmp_hit
            | (flag_q[FLG_CH] & ~(wr_flag & pwdata[FLG_CH]));
         eq_q <= eq;
         eq2_q <= eq2;
         cap_cnt_q <= wr_ctrl ? 4'h0 : cap_cnt_q + {3'b000, rise & cap_mode};
         if (wr_ctrl) begin
            cmp_pin_q <= (pwdata[3:0] == MODE_CMP_CLR);
         end else if (cmp_hit) begin
            case (mode)
               MODE_CMP_TOG: cmp_pin_q <= ~cmp_pin_q;
               MODE_CMP_SET: cmp_pin_q <= 1'b1;
               MODE_CMP_CLR: cmp_pin_q <= 1'b0;
               default: cmp_pin_q <= cmp_pin_q;
            endcase
         end
      end
   end

   // Compare runs on the instruction clock, the low duty bits on the quarter phase at prescale 1 and on the prescaler bits otherwise.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {qcyc_q, pre_q, pwm_tmr_q, dbuf_q, pwm_raw_q} <= '0;
         {sd_flag_q, sd_hold_q} <= 2'b00;
         {pin_q, oe_n_q} <= {4'h0, 4'hF};
      end else begin
         qcyc_q <= qcyc_q + 2'h1;
         if (pctl_q[PCTL_ON] & instr) begin
            pre_q <= pre_q + 4'h1;
         end
         if (pwr) begin
            pwm_tmr_q <= 8'h0;
         end else if (ptick) begin
            pwm_tmr_q <= pwm_tmr_q + 8'h1;
         end
         if (!pwm_mode) begin
            pwm_raw_q <= 1'b0;
         end else if (pwr) begin
            dbuf_q <= duty_prog;
            pwm_raw_q <= (duty_prog != 10'h0);
         end else if (pwm_cnt == dbuf_q) begin
            pwm_raw_q <= 1'b0;
         end
         // In a PWM mode, software may not clear the flag while the fault is still present.
         if (sd_cause & pwm_mode) begin
            sd_flag_q <= 1'b1;
         end else if (pcfg_q[PCFG_RESTART]) begin
            sd_flag_q <= 1'b0;
         end else if (wr_sdc) begin
            sd_flag_q <= pwdata[SDC_ACT];
         end
         if (pwr) begin
            sd_hold_q <= sd_flag_q;
         end
         pin_q <= pin_d;
         oe_n_q <= ~drv_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign adc_start = adc_start_q;
   assign alt_timer_clear = alt_clr_q;
   assign {bridge_out_d_o, bridge_out_c_o, bridge_out_b_o, bridge_out_a_o} = pin_q;
   assign {bridge_out_d_oe_n, bridge_out_c_oe_n, bridge_out_b_oe_n, bridge_out_a_oe_n} = oe_n_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence period_start_shut;
      pwr && sd_flag_q;
   endsequence
   sequence duty_match;
      pwm_mode && !pwr && (pwm_cnt == dbuf_q);
   endsequence
   wrap_overflow_a: assert property (wrap |=> flag_q[FLG_OVF] && event_timer_q == 16'h0000)
      else $error("wrap did not set overflow and zero timer");
   special_clear_a: assert property (tmr_clr && !wr_tmr |=> event_timer_q == 16'h0000)
      else $error("special event did not clear timer");
   write_wins_a: assert property (wr_tmr |=> event_timer_q == $past(pwdata[15:0]))
      else $error("timer write lost");
   adc_trigger_a: assert property (sec_spec && adc_enabled |=> adc_start ##1 !adc_start)
      else $error("conversion start not a single pulse");
   no_ovf_second_a: assert property (sec_spec && !flag_q[FLG_OVF] |=> !flag_q[FLG_OVF])
      else $error("second channel reset set overflow");
   irq_gate_a: assert property (irq |-> $past(|(flag_q & ien_q)))
      else $error("interrupt without enabled flag");
   duty_load_a: assert property (pwr && pwm_mode |=> dbuf_q == $past(duty_prog))
      else $error("duty buffer not loaded at wrap");
   duty_clear_a: assert property (duty_match |=> !pwm_raw_q)
      else $error("output not cleared on duty match");
   capture_copy_a: assert property (cap_evt && !wr |=> cmp_q == $past(sel_tmr) && flag_q[FLG_CH])
      else $error("capture did not copy timer");
   shut_hold_a: assert property (period_start_shut |=> sd_hold_q [*2])
      else $error("shutdown not held through period");
endmodule : ecpw_unit

// ### tb/ecpw_bridge_model.sv
// Behavioural model of the bridge switches and pins on the far side of the unit.
`timescale 1ns/100ps
module ecpw_bridge_model (
   // Clock
   input wire logic pclk,
   // Unit drive, enables low while driven, external source on pin A
   input wire logic [3:0] drv,
   input wire logic [3:0] oe_n,
   input wire logic cap_in,
   // Resolved pin levels
   output logic [3:0] pin
);
   logic tog_q = 1'b0;
   // A released pin B, C or D has no keeper, so it wanders rather than holding its last level.
   always_ff @(posedge pclk) begin
      tog_q <= ~tog_q;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin[i] = oe_n[i] ? ((i == 0) ? cap_in : tog_q) : drv[i];
      end
   end
endmodule : ecpw_bridge_model

// ### tb/testbench.sv
// Self-checking testbench of the capture/compare/PWM unit.
`timescale 1ns/100ps
module testbench;
   import ecpw_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, event_tick, adc_enabled, cap_in, err, fault_n;
   logic pready, pslverr, alt_timer_clear, adc_start, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, v, a0;
   logic [15:0] alt_timer_value;
   logic [3:0] drv, oe_n, pin;
   logic [7:0] e;
   int n_mismatch, num_checks, cyc, n_adc;
   ecpw_unit ecpw_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_tick(event_tick), .alt_timer_value(alt_timer_value),
      .alt_timer_clear(alt_timer_clear), .adc_enabled(adc_enabled), .adc_start(adc_start),
      .irq(irq), .fault_n_i(fault_n), .bridge_out_a_i(pin[0]), .bridge_out_a_o(drv[0]),
      .bridge_out_a_oe_n(oe_n[0]), .bridge_out_b_o(drv[1]), .bridge_out_b_oe_n(oe_n[1]),
      .bridge_out_c_o(drv[2]), .bridge_out_c_oe_n(oe_n[2]), .bridge_out_d_o(drv[3]),
      .bridge_out_d_oe_n(oe_n[3]));
   ecpw_bridge_model ecpw_bridge_model_i (.pclk(pclk), .drv(drv), .oe_n(oe_n),
      .cap_in(cap_in), .pin(pin));
   // ----------------------------------------------------------------
   // Clock, timeout and tasks
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (adc_start === 1'b1) n_adc <= n_adc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         wrap_up();
      end
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   // Every field but penable is held from setup until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         event_tick <= 1'b1;
      end
      @(posedge pclk);
      event_tick <= 1'b0;
   endtask : ticks
   // Pins {d,c,b,a}: enables then levels, with the duty held above the period.
   function logic [7:0] exp_pwm(input logic [1:0] s, input logic [1:0] p);
      logic [7:0] r;
      case (s)
         2'd0: r = 8'hE1;
         2'd1: r = 8'h09;
         2'd2: r = 8'hC1;
         default: r = 8'h06;
      endcase
      r[3:0] = (r[3:0] ^ {p[0], p[1], p[0], p[1]}) & ~r[7:4];
      return r;
   endfunction : exp_pwm
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc = 0; n_adc = 0; n_mismatch = 0; num_checks = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; event_tick = 1'b0; adc_enabled = 1'b0; cap_in = 1'b0; fault_n = 1'b1;
      v = $urandom(32'h0962);
      alt_timer_value = $urandom;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_CTRL, 0); chk("ctrl", {24'h0, CTRL_RST}, rd);
      apb(0, OFS_PER, 0); chk("period", {24'h0, PER_RST}, rd);
      apb(0, 8'h30, 0); chk("slverr", 1, {31'h0, err});
      apb(1, OFS_IEN, 1); apb(1, OFS_TMR, 32'hFFFE); ticks(3);
      apb(0, OFS_TMR, 0); chk("timer", 1, rd);
      apb(0, OFS_FLAG, 0); chk("flags", 1, rd);
      chk("irq", 1, {31'h0, irq});
      v = $urandom_range(32'hF000, 32'h0100);
      apb(1, OFS_FLAG, 3); apb(1, OFS_CMP, v); apb(1, OFS_CTRL, MODE_CMP_SPEC);
      apb(1, OFS_TMR, v - 4); ticks(6);
      apb(0, OFS_TMR, 0); chk("clear", 1, {31'h0, rd[15:0] < 16'h0004});
      apb(0, OFS_FLAG, 0); chk("flags", 2, rd);
      apb(1, OFS_CTRL, 0); apb(1, OFS_CMP2, {12'h0, MODE_CMP_SPEC, v[15:0]});
      for (int en = 0; en < 2; en++) begin
         a0 = n_adc;
         adc_enabled <= en[0];
         apb(1, OFS_FLAG, 3); apb(1, OFS_TMR, v - 2); ticks(4);
         apb(0, OFS_FLAG, 0); chk("flags", 0, rd);
         chk("adc", en, n_adc - a0);
      end
      v = $urandom;
      apb(1, OFS_CMP2, 0); apb(1, OFS_CTRL, MODE_CAP_RISE); apb(1, OFS_FLAG, 3);
      apb(1, OFS_TMR, v[15:0]);
      cap_in <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(0, OFS_CMP, 0); chk("capture", v[15:0], rd);
      chk("released", 7, oe_n[3:1]);
      apb(1, OFS_PER, 3); apb(1, OFS_DUTY, 8'hFF); apb(1, OFS_PCTL, 4);
      for (int s = 0; s < 4; s++) begin
         v = $urandom;
         apb(1, OFS_CTRL, {s[1:0], 2'b11, 2'b11, v[1:0]});
         repeat (40) @(posedge pclk);
         e = exp_pwm(s[1:0], v[1:0]);
         chk("enables", e[7:4], oe_n);
         chk("levels", e[3:0], drv & ~e[7:4]);
      end
      // A fault forces pin A low until auto restart releases it at a period start.
      apb(1, OFS_CTRL, 8'h3C); apb(1, OFS_PCFG, 8'h80); apb(1, OFS_SDC, 32'h10);
      fault_n <= 1'b0;
      repeat (40) @(posedge pclk);
      apb(0, OFS_SDC, 0); chk("shutdown flag", 32'h90, rd);
      chk("shutdown level", 0, drv[0]);
      fault_n <= 1'b1;
      repeat (40) @(posedge pclk);
      apb(0, OFS_SDC, 0); chk("restart flag", 32'h10, rd);
      chk("restart level", 1, drv[0]);
      apb(1, OFS_DUTY, 0); apb(1, OFS_CTRL, 8'h0C);
      repeat (40) @(posedge pclk);
      chk("zero duty", 0, drv[0]);
      wrap_up();
   end
endmodule : testbench
